// File: spi_port_pkg.sv
// Constants, field layouts and state type for the host serial port.
// Assumes one 200 MHz system clock; link pins are sampled, never used as clocks.
package spi_port_pkg;
  localparam logic [1:0] OP_REG_WR = 2'h0;
  localparam logic [1:0] OP_REG_RD = 2'h1;
  localparam logic [1:0] OP_MEM = 2'h2;
  localparam logic [1:0] OP_CMD = 2'h3;
  localparam logic [5:0] TRL_FIFO_LD = 6'h00;
  localparam logic [5:0] TRL_MEM_A = 6'h20;
  localparam logic [5:0] TRL_MEM_F = 6'h28;
  localparam logic [5:0] TRL_MEM_T = 6'h2C;
  localparam logic [5:0] TRL_MEM_RD = 6'h3F;
  localparam logic [5:0] TRL_FIFO_RD = 6'h1F;
  localparam logic [5:0] MEM_BASE_A = 6'h00;
  localparam logic [5:0] MEM_BASE_F = 6'h0F;
  localparam logic [5:0] MEM_BASE_T = 6'h24;
  localparam logic [7:0] SPACE_B_PREFIX = 8'hFB;
  localparam logic [5:0] IO_CFG1_ADDR = 6'h02;
  localparam logic [5:0] IO_CFG2_ADDR = 6'h03;
  localparam int CFG1_CLKSEL_LSB = 0;
  localparam int CFG1_LFOFF_BIT = 2;
  localparam int CFG2_PDA_BIT = 0;
  localparam int CFG2_PDB_BIT = 1;
  localparam logic [1:0] CLKSEL_OFF = 2'h0;
  localparam logic [1:0] CLKSEL_DIV1 = 2'h1;
  localparam logic [1:0] CLKSEL_DIV2 = 2'h2;
  localparam logic [1:0] CLKSEL_DIV4 = 2'h3;
  localparam logic [1:0] CLKSEL_RST = CLKSEL_DIV4;
  localparam logic LFOFF_RST = 1'h0;
  localparam int LOAD_W = 15;
  typedef enum logic [3:0] {ST_OP, ST_WR, ST_RD, ST_FLD, ST_MLD, ST_FRD, ST_MRD, ST_CMD,
    ST_IGN} op_state_e;
endpackage

// File: pair_buffer.sv
// Two-entry valid/ready buffer for bytes bound for the FIFO or target memory.
// Assumes both sides run on the system clock; all outputs come from flops.
`timescale 1ns/1ps
module pair_buffer #(
  parameter int W = 15
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] head_r;
  logic [W-1:0] tail_r;
  logic head_v_r;
  logic tail_v_r;
  logic push;
  logic pop;

  assign push = in_valid && !tail_v_r;
  assign pop = head_v_r && out_ready;
  assign in_ready = !tail_v_r;
  assign out_valid = head_v_r;
  assign out_data = head_r;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      head_v_r <= 1'b0;
      tail_v_r <= 1'b0;
      head_r <= '0;
      tail_r <= '0;
    end
    else if (pop && tail_v_r)
    begin
      head_r <= tail_r;
      tail_v_r <= 1'b0;
    end
    else if (pop)
    begin
      head_v_r <= push;
      head_r <= in_data;
    end
    else if (push && !head_v_r)
    begin
      head_r <= in_data;
      head_v_r <= 1'b1;
    end
    else if (push)
    begin
      tail_r <= in_data;
      tail_v_r <= 1'b1;
    end
  end

  full_stall_a: assert property (@(posedge clock) disable iff (srst)
    (head_v_r && tail_v_r && !out_ready) |=> !in_ready)
    else $error("buffer accepted while full");
endmodule

// File: host_clock_out.sv
// Host clock output: crystal clock divided by 1, 2 or 4, or the slow RC clock.
// Assumes crystal and RC clocks arrive as pins; both are sampled twice first.
`timescale 1ns/1ps
module host_clock_out
  import spi_port_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Source clocks and state
  input wire logic xtal_clk,
  input wire logic lf_clk,
  input wire logic xtal_running,
  // Configuration
  input wire logic [1:0] clk_sel,
  input wire logic lf_off,
  // Host clock pin
  output logic host_clk
);
  logic [2:0] xs_r;
  logic [1:0] ls_r;
  logic [1:0] div_r;
  logic host_clk_r;

  always_ff @(posedge clock)
  begin
    xs_r <= {xs_r[1:0], xtal_clk};
    ls_r <= {ls_r[0], lf_clk};
  end

  // Count crystal rising edges; bit 0 halves, bit 1 quarters
  always_ff @(posedge clock)
  begin
    if (srst)
      div_r <= 2'h0;
    else if (xs_r[1] && !xs_r[2])
      div_r <= div_r + 2'h1;
  end

  always_ff @(posedge clock)
  begin
    if (srst || clk_sel == CLKSEL_OFF)
      host_clk_r <= 1'b0;
    else if (xtal_running)
    begin
      case (clk_sel)
        CLKSEL_DIV1: host_clk_r <= xs_r[1];
        CLKSEL_DIV2: host_clk_r <= div_r[0];
        default: host_clk_r <= div_r[1];
      endcase
    end
    else
      host_clk_r <= ls_r[1] && !lf_off;
  end

  assign host_clk = host_clk_r;

  clk_off_a: assert property (@(posedge clock) disable iff (srst)
    (clk_sel == CLKSEL_OFF) |=> !host_clk)
    else $error("host clock driven while disabled");
  lf_gate_a: assert property (@(posedge clock) disable iff (srst)
    (!xtal_running && lf_off) |=> !host_clk)
    else $error("slow clock shown while turned off");
endmodule

// File: spi_host_port.sv
// Serial slave port: decodes operation bytes, streams registers, FIFO, memory.
// Assumes link pins are asynchronous and slow (clock period well over 20 cycles).
`timescale 1ns/1ps
module spi_host_port
  import spi_port_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Interface select strap
  input wire logic iface_strap,
  output logic twowire_mode,
  // Serial link pins
  input wire logic sclk,
  input wire logic slave_select_n,
  input wire logic mosi,
  output logic sdo_o,
  output logic sdo_oe,
  output logic sdo_pd_en,
  // Operating state and clocks
  input wire logic main_enable,
  input wire logic xtal_stable,
  input wire logic xtal_running,
  input wire logic xtal_clk,
  input wire logic lf_clk,
  output logic host_clk,
  // Register access
  output logic reg_space_b,
  output logic [5:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic reg_writable,
  output logic reg_rd,
  input wire logic reg_readable,
  input wire logic [7:0] reg_rdata,
  // FIFO and target memory reads
  output logic fifo_pop,
  input wire logic [7:0] fifo_rdata,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  // FIFO and target memory loads
  output logic load_valid,
  input wire logic load_ready,
  output logic [7:0] load_data,
  output logic load_to_mem,
  output logic [5:0] load_addr,
  output logic load_lost,
  // Direct command
  output logic [5:0] cmd_code,
  input wire logic cmd_any_state,
  output logic cmd_go
);
  logic [2:0] pin1_r;
  logic [2:0] pin2_r;
  logic [2:0] pin3_r;
  logic strap1_r;
  logic strap2_r;
  logic twowire_r;
  logic sel;
  logic sel_d;
  logic sclk_rise;
  logic sclk_fall;
  logic [2:0] bit_cnt_r;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_byte;
  logic byte_done;
  logic gate_ok;
  logic at_op;
  logic is_rd;
  op_state_e state_r;
  logic space_b_r;
  logic [5:0] addr_r;
  logic [5:0] reg_addr_r;
  logic [5:0] cmd_code_r;
  logic cmd_go_r;
  logic fetch_r;
  logic capture_r;
  logic reg_rd_r;
  logic fifo_pop_r;
  logic mem_rd_r;
  logic [7:0] tx_byte_r;
  logic [7:0] tx_sh_r;
  logic sdo_r;
  logic sdo_oe_r;
  logic sdo_pd_r;
  logic reg_wr_r;
  logic [7:0] reg_wdata_r;
  logic [1:0] clk_sel_r;
  logic lf_off_r;
  logic pd_a_r;
  logic pd_b_r;
  logic cfg1_hit;
  logic cfg2_hit;
  logic push_r;
  logic [LOAD_W-1:0] push_data_r;
  logic buf_ready;
  logic [LOAD_W-1:0] buf_data;
  logic load_lost_r;

  function automatic op_state_e decode_op(input logic [7:0] b, input logic ok);
    op_state_e s;
    s = ST_IGN;
    case (b[7:6])
      OP_REG_WR: s = ST_WR;
      OP_REG_RD: s = ST_RD;
      OP_CMD: s = ST_CMD;
      default:
      begin
        case (b[5:0])
          TRL_FIFO_LD: s = ST_FLD;
          TRL_MEM_A, TRL_MEM_F, TRL_MEM_T: s = ST_MLD;
          TRL_MEM_RD: s = ST_MRD;
          TRL_FIFO_RD: s = ST_FRD;
          default: s = ST_IGN;
        endcase
        if (!ok)
          s = ST_IGN;
      end
    endcase
    return s;
  endfunction

  function automatic logic [5:0] start_addr(input logic [7:0] b);
    logic [5:0] a;
    a = b[5:0];
    if (b[7:6] == OP_MEM)
    begin
      case (b[5:0])
        TRL_MEM_F: a = MEM_BASE_F;
        TRL_MEM_T: a = MEM_BASE_T;
        default: a = MEM_BASE_A;
      endcase
    end
    return a;
  endfunction

  // Link pins: two flops before use, third only for edge finding
  always_ff @(posedge clock)
  begin
    pin1_r <= {sclk, slave_select_n, mosi};
    pin2_r <= pin1_r;
    pin3_r <= pin2_r;
    strap1_r <= iface_strap;
    strap2_r <= strap1_r;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      twowire_r <= 1'b0;
    else
      twowire_r <= strap2_r;
  end

  // Two-wire mode keeps this port deselected
  assign sel = !pin2_r[1] && !twowire_r;
  assign sel_d = !pin3_r[1] && !twowire_r;
  assign sclk_rise = sel && pin2_r[2] && !pin3_r[2];
  assign sclk_fall = sel && !pin2_r[2] && pin3_r[2];
  assign rx_byte = {rx_sh_r[6:0], pin2_r[0]};
  assign byte_done = sclk_fall && bit_cnt_r == 3'h7;
  assign gate_ok = main_enable && xtal_stable;
  assign at_op = state_r == ST_OP || state_r == ST_CMD;
  assign is_rd = state_r == ST_RD || state_r == ST_FRD || state_r == ST_MRD;
  assign cfg1_hit = !space_b_r && reg_addr_r == IO_CFG1_ADDR;
  assign cfg2_hit = !space_b_r && reg_addr_r == IO_CFG2_ADDR;

  always_ff @(posedge clock)
  begin
    if (srst || !sel)
      bit_cnt_r <= 3'h0;
    else if (sclk_fall)
      bit_cnt_r <= bit_cnt_r + 3'h1;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      rx_sh_r <= 8'h00;
    else if (sclk_fall)
      rx_sh_r <= rx_byte;
  end

  always_ff @(posedge clock)
  begin
    if (srst || !sel)
    begin
      state_r <= ST_OP;
      space_b_r <= 1'b0;
    end
    else if (byte_done && at_op)
    begin
      // Prefix is tested first; it would otherwise decode as a command
      if (rx_byte == SPACE_B_PREFIX)
      begin
        space_b_r <= 1'b1;
        state_r <= ST_OP;
      end
      else
        state_r <= decode_op(rx_byte, gate_ok);
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      addr_r <= 6'h00;
    else if (byte_done && at_op)
      addr_r <= start_addr(rx_byte);
    else if (byte_done && state_r inside {ST_WR, ST_RD, ST_MLD, ST_MRD})
      addr_r <= addr_r + 6'h01;
  end

  // Lags addr_r by one cycle so a write strobe carries the byte's own address
  always_ff @(posedge clock)
  begin
    if (srst)
      reg_addr_r <= 6'h00;
    else
      reg_addr_r <= addr_r;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cmd_code_r <= 6'h00;
      cmd_go_r <= 1'b0;
    end
    else
    begin
      if (byte_done && at_op && rx_byte[7:6] == OP_CMD)
        cmd_code_r <= rx_byte[5:0];
      // Runs at select rise, or at the next byte when chained
      cmd_go_r <= state_r == ST_CMD && ((sel_d && !sel) || byte_done)
        && (cmd_any_state || gate_ok);
    end
  end

  // Fetch one cycle after the byte ends, capture the answer one later
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      fetch_r <= 1'b0;
      capture_r <= 1'b0;
      reg_rd_r <= 1'b0;
      fifo_pop_r <= 1'b0;
      mem_rd_r <= 1'b0;
    end
    else
    begin
      fetch_r <= byte_done;
      capture_r <= fetch_r && is_rd;
      reg_rd_r <= fetch_r && state_r == ST_RD;
      fifo_pop_r <= fetch_r && state_r == ST_FRD;
      mem_rd_r <= fetch_r && state_r == ST_MRD;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      tx_byte_r <= 8'h00;
    else if (capture_r)
    begin
      case (state_r)
        ST_FRD: tx_byte_r <= fifo_rdata;
        ST_MRD: tx_byte_r <= mem_rdata;
        default:
        begin
          if (cfg1_hit)
            tx_byte_r <= {5'h00, lf_off_r, clk_sel_r};
          else if (cfg2_hit)
            tx_byte_r <= {6'h00, pd_b_r, pd_a_r};
          else
            tx_byte_r <= reg_readable ? reg_rdata : 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst || !sel)
    begin
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
      tx_sh_r <= 8'h00;
    end
    else if (sclk_rise && is_rd)
    begin
      sdo_oe_r <= 1'b1;
      if (bit_cnt_r == 3'h0)
      begin
        sdo_r <= tx_byte_r[7];
        tx_sh_r <= {tx_byte_r[6:0], 1'b0};
      end
      else
      begin
        sdo_r <= tx_sh_r[7];
        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      sdo_pd_r <= 1'b0;
    else
      sdo_pd_r <= !sdo_oe_r && pd_a_r && pd_b_r;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      reg_wr_r <= 1'b0;
      reg_wdata_r <= 8'h00;
    end
    else
    begin
      reg_wr_r <= byte_done && state_r == ST_WR && reg_writable
        && !cfg1_hit && !cfg2_hit;
      if (byte_done)
        reg_wdata_r <= rx_byte;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      clk_sel_r <= CLKSEL_RST;
      lf_off_r <= LFOFF_RST;
      pd_a_r <= 1'b0;
      pd_b_r <= 1'b0;
    end
    else if (byte_done && state_r == ST_WR && cfg1_hit)
    begin
      clk_sel_r <= rx_byte[CFG1_CLKSEL_LSB +: 2];
      lf_off_r <= rx_byte[CFG1_LFOFF_BIT];
    end
    else if (byte_done && state_r == ST_WR && cfg2_hit)
    begin
      pd_a_r <= rx_byte[CFG2_PDA_BIT];
      pd_b_r <= rx_byte[CFG2_PDB_BIT];
    end
  end

  // Load path; the master may not outpace the drain, see the lost flag
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      push_r <= 1'b0;
      push_data_r <= '0;
    end
    else
    begin
      push_r <= byte_done && (state_r == ST_FLD || state_r == ST_MLD);
      if (byte_done)
        push_data_r <= {state_r == ST_MLD, addr_r, rx_byte};
    end
  end

  // Set wins over the clear at the start of a new selection
  always_ff @(posedge clock)
  begin
    if (srst)
      load_lost_r <= 1'b0;
    else if (push_r && !buf_ready)
      load_lost_r <= 1'b1;
    else if (sel && !sel_d)
      load_lost_r <= 1'b0;
  end

  pair_buffer #(
    .W(LOAD_W)
  ) u_load_buf (
    .clock(clock),
    .srst(srst),
    .in_valid(push_r),
    .in_ready(buf_ready),
    .in_data(push_data_r),
    .out_valid(load_valid),
    .out_ready(load_ready),
    .out_data(buf_data)
  );

  host_clock_out u_host_clk (
    .clock(clock),
    .srst(srst),
    .xtal_clk(xtal_clk),
    .lf_clk(lf_clk),
    .xtal_running(xtal_running),
    .clk_sel(clk_sel_r),
    .lf_off(lf_off_r),
    .host_clk(host_clk)
  );

  assign twowire_mode = twowire_r;
  assign sdo_o = sdo_r;
  assign sdo_oe = sdo_oe_r;
  assign sdo_pd_en = sdo_pd_r;
  assign reg_space_b = space_b_r;
  assign reg_addr = reg_addr_r;
  assign reg_wr = reg_wr_r;
  assign reg_wdata = reg_wdata_r;
  assign reg_rd = reg_rd_r;
  assign fifo_pop = fifo_pop_r;
  assign mem_rd = mem_rd_r;
  assign load_to_mem = buf_data[14];
  assign load_addr = buf_data[13:8];
  assign load_data = buf_data[7:0];
  assign load_lost = load_lost_r;
  assign cmd_code = cmd_code_r;
  assign cmd_go = cmd_go_r;

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  sdo_float_a: assert property (!sel |=> !sdo_oe)
    else $error("data out driven while deselected");
  gate_mem_a: assert property (byte_done && at_op && rx_byte[7:6] == OP_MEM
    && rx_byte != SPACE_B_PREFIX && !gate_ok |=> state_r == ST_IGN)
    else $error("memory operation accepted while gated");
  wr_commit_a: assert property (reg_wr |-> $past(byte_done && state_r == ST_WR))
    else $error("write strobe without a finished byte");
  addr_step_a: assert property (byte_done && state_r inside {ST_WR, ST_RD}
    |=> addr_r == $past(addr_r) + 6'h01)
    else $error("address did not step by one");
  spaceb_end_a: assert property (!sel |=> !reg_space_b)
    else $error("second space kept after select rose");
  rd_fetch_a: assert property (byte_done && at_op && sel
    && decode_op(rx_byte, gate_ok) == ST_RD && rx_byte != SPACE_B_PREFIX
    |-> ##2 reg_rd)
    else $error("register read not fetched");
  msb_out_a: assert property (sclk_rise && is_rd && bit_cnt_r == 3'h0
    |=> sdo_o == $past(tx_byte_r[7]) && sdo_oe)
    else $error("byte not sent msb first");
  cmd_rise_a: assert property (cmd_go |-> $past(state_r) == ST_CMD)
    else $error("command issued outside command byte");
endmodule

// File: spi_host_model.sv
// Host-side serial master model: drives select, clock and data in, reads data out.
// Assumes the bench clock; every pin change lands on its falling edge.
`timescale 1ns/1ps
module spi_host_model (
  // Bench clock
  input wire logic clock,
  // Link pins
  output logic sclk,
  output logic slave_select_n,
  output logic mosi,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic sdo_pd_en
);
  logic sdo_last;
  logic sdo_line;
  // Floating line shows the inverse of its last value unless pulled down
  assign sdo_line = sdo_oe ? sdo_o : (sdo_pd_en ? 1'b0 : ~sdo_last);
  always @(posedge clock)
    if (sdo_oe)
      sdo_last <= sdo_o;
  initial
  begin
    sclk = 1'b0;
    slave_select_n = 1'b1;
    mosi = 1'b0;
    sdo_last = 1'b0;
  end
  task automatic start();
    @(negedge clock);
    slave_select_n = 1'b0;
    repeat (12) @(negedge clock);
  endtask
  // Whole bytes only, MSB first; data out taken just before each fall
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge clock);
      sclk = 1'b1;
      mosi = tx[i];
      repeat (12) @(negedge clock);
      rx[i] = sdo_line;
      sclk = 1'b0;
      repeat (12) @(negedge clock);
    end
  endtask
  task automatic stop();
    repeat (12) @(negedge clock);
    slave_select_n = 1'b1;
    mosi = ~mosi;
    repeat (24) @(negedge clock);
  endtask
endmodule

// File: spi_host_port_tb.sv
// Self-checking bench for the host serial port and host clock output.
// Assumes the partner master model; bench plays FIFO, memory and register file.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h got %h", nm, e, g); end end
module spi_host_port_tb;
  import spi_port_pkg::*;
  logic clock, srst, iface_strap, twowire_mode, sclk, slave_select_n, mosi;
  logic sdo_o, sdo_oe, sdo_pd_en, main_enable, xtal_stable, xtal_running;
  logic xtal_clk, lf_clk, host_clk, reg_space_b, reg_wr, reg_writable, reg_rd;
  logic reg_readable, fifo_pop, mem_rd, load_valid, load_ready, load_to_mem;
  logic load_lost, cmd_any_state, cmd_go, hclk_d;
  logic [5:0] reg_addr, load_addr, cmd_code;
  logic [7:0] reg_wdata, reg_rdata, fifo_rdata, mem_rdata, load_data, fcnt, rx;
  logic [7:0] rxq[$];
  logic [14:0] wrq[$];
  logic [14:0] ldq[$];
  logic [7:0] lop[3] = '{8'hA0, 8'hA8, 8'hAC};
  logic [5:0] lbase[3] = '{6'h00, 6'h0F, 6'h24};
  int n_fail = 0;
  int check_count = 0;
  int hrise = 0;
  int ngo = 0;
  int h;
  spi_host_port dut (.*);
  spi_host_model m (.*);
  // Read-only register sits at 10h
  assign reg_writable = reg_addr != 6'h10;
  // Read data stands only with its strobe; the port takes it at that edge
  assign reg_readable = reg_addr < 6'h30;
  assign reg_rdata = reg_rd ? ({reg_space_b, 1'b0, reg_addr} ^ 8'h5A) : 8'h00;
  assign fifo_rdata = fifo_pop ? fcnt : 8'h00;
  assign mem_rdata = mem_rd ? ({2'h0, reg_addr} ^ 8'h3C) : 8'h00;
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    xtal_clk = 1'b0;
    forever #37 xtal_clk = ~xtal_clk;
  end
  initial
  begin
    lf_clk = 1'b0;
    forever #500 lf_clk = ~lf_clk;
  end
  always @(posedge clock)
  begin
    hclk_d <= host_clk;
    if (host_clk && !hclk_d)
      hrise <= hrise + 1;
    if (reg_wr)
      wrq.push_back({reg_space_b, reg_addr, reg_wdata});
    if (load_valid && load_ready)
      ldq.push_back({load_to_mem, load_addr, load_data});
    if (cmd_go)
      ngo <= ngo + 1;
    if (fifo_pop)
      fcnt <= fcnt + 8'h01;
  end
  task automatic frame(input logic [7:0] tx[$]);
    logic [7:0] r;
    rxq.delete();
    m.start();
    foreach (tx[i])
    begin
      m.xfer(tx[i], r);
      rxq.push_back(r);
    end
    m.stop();
  endtask
  // Host clock rises counted over 3000 ns, one either side allowed for jitter
  task automatic hmeas(input int e);
    int h0;
    h0 = hrise;
    repeat (600) @(negedge clock);
    `CHK("host_clk rises", 1'b1, (hrise - h0 >= e - 1) && (hrise - h0 <= e + 1))
  endtask
  task automatic test_done();
    $display("Checks %0d, errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_fail++;
    test_done();
  end
  initial
  begin
    srst = 1'b1;
    iface_strap = 1'b0;
    main_enable = 1'b0;
    xtal_stable = 1'b1;
    xtal_running = 1'b1;
    load_ready = 1'b1;
    cmd_any_state = 1'b0;
    fcnt = 8'hC0;
    hclk_d = 1'b0;
    repeat (5) @(negedge clock);
    srst = 1'b0;
    repeat (3) @(negedge clock);
    `CHK("twowire_mode", 1'b0, twowire_mode)
    hmeas(3000 / 74 / 4);
    for (int s = 1; s < 4; s++)
    begin
      frame('{8'h02, 8'(s)});
      hmeas(3000 / 74 / (1 << (s - 1)));
      frame('{8'h42, 8'h00});
      `CHK("clock config", 8'(s), rxq[1])
    end
    frame('{8'h02, 8'h00});
    hmeas(0);
    xtal_running = 1'b0;
    frame('{8'h02, 8'h03});
    hmeas(3);
    frame('{8'h02, 8'h07});
    hmeas(0);
    xtal_running = 1'b1;
    wrq.delete();
    frame('{8'h0F, 8'hA1, 8'hA2, 8'hA3});
    frame('{8'hFB, 8'h0F, 8'h77});
    frame('{8'h20, 8'h12});
    iface_strap = 1'b1;
    repeat (8) @(negedge clock);
    `CHK("twowire_mode", 1'b1, twowire_mode)
    frame('{8'h21, 8'h99});
    iface_strap = 1'b0;
    repeat (8) @(negedge clock);
    `CHK("write count", 4, wrq.size())
    `CHK("write 0", {1'b0, 6'h0F, 8'hA1}, wrq[0])
    `CHK("write 1", {1'b0, 6'h11, 8'hA3}, wrq[1])
    `CHK("write 2", {1'b1, 6'h0F, 8'h77}, wrq[2])
    `CHK("write 3", {1'b0, 6'h20, 8'h12}, wrq[3])
    frame('{8'h6E, 8'h00, 8'h00, 8'h00});
    for (int i = 0; i < 2; i++)
      `CHK("read", {2'h0, 6'h2E + 6'(i)} ^ 8'h5A, rxq[i + 1])
    `CHK("read unmapped", 8'h00, rxq[3])
    `CHK("sdo_oe idle", 1'b0, sdo_oe)
    frame('{8'hFB, 8'h6E, 8'h00});
    `CHK("read space b", 8'hAE ^ 8'h5A, rxq[2])
    frame('{8'h03, 8'h03});
    `CHK("pulldown on", 1'b1, sdo_pd_en)
    frame('{8'h43, 8'h00});
    `CHK("pulldown cfg", 8'h03, rxq[1])
    frame('{8'h03, 8'h01});
    `CHK("pulldown off", 1'b0, sdo_pd_en)
    ldq.delete();
    frame('{8'h80, 8'h11});
    `CHK("gated load", 0, ldq.size())
    main_enable = 1'b1;
    frame('{8'h80, 8'h11, 8'h22});
    `CHK("fifo load", 9'h011, {ldq[0][14], ldq[0][7:0]})
    `CHK("fifo load", 9'h022, {ldq[1][14], ldq[1][7:0]})
    for (int k = 0; k < 3; k++)
    begin
      ldq.delete();
      frame('{lop[k], 8'h30, 8'h31});
      `CHK("mem load", {1'b1, lbase[k], 8'h30}, ldq[0])
      `CHK("mem load", {1'b1, lbase[k] + 6'h01, 8'h31}, ldq[1])
    end
    ldq.delete();
    load_ready = 1'b0;
    frame('{8'h80, 8'h41, 8'h42, 8'h43, 8'h44});
    `CHK("load_lost", 1'b1, load_lost)
    load_ready = 1'b1;
    repeat (8) @(negedge clock);
    `CHK("stalled order", 16'h4142, {ldq[0][7:0], ldq[1][7:0]})
    frame('{8'h80, 8'h55});
    `CHK("load_lost clear", 1'b0, load_lost)
    frame('{8'h9F, 8'h00, 8'h00});
    `CHK("fifo read", 16'hC0C1, {rxq[1], rxq[2]})
    frame('{8'hBF, 8'h00, 8'h00});
    `CHK("mem read", 16'h3C3D, {rxq[1], rxq[2]})
    main_enable = 1'b0;
    cmd_any_state = 1'b1;
    h = ngo;
    m.start();
    m.xfer(8'hC5, rx);
    repeat (30) @(negedge clock);
    `CHK("early go", h, ngo)
    m.stop();
    `CHK("go", h + 1, ngo)
    `CHK("cmd_code", 6'h05, cmd_code)
    cmd_any_state = 1'b0;
    frame('{8'hC6});
    `CHK("gated go", h + 1, ngo)
    main_enable = 1'b1;
    frame('{8'hC7, 8'h6E, 8'h00});
    `CHK("chained go", h + 2, ngo)
    `CHK("chained code", 6'h07, cmd_code)
    `CHK("chained read", 8'h2E ^ 8'h5A, rxq[2])
    test_done();
  end
endmodule
